// ### auxio_regs.sv
// Auxiliary DAC, I/O and miscellaneous control register bank
//
// Functional notes
// - Miscellaneous control is a 16-bit read/write register.
// - Data-ready configuration bits are kept across any reset.
// - Self-test control bits clear to zero on every reset.
// - Bit 10 clear runs self-test after reset, about 13 or 35 ms.
// - Bit 9 reverses rotation sense of both inclination outputs.
// - Bit 8 runs self-test continuously; clear disables it.
// - Bits 2,1,0: data-ready enable, polarity, line select.
// - Data-ready pulses active at sample done, inactive partway into next cycle.
// - Pin owner priority: misc control, then alarm, then I/O control.
// - DAC output updates only on latch command bit 2, not byte writes.
// - DAC bits 11:0 are an unsigned code, 0 to full scale.
// - DAC data register clears to zero on reset.
// - I/O control clears on reset, both lines inputs.
// - I/O control bits 1,0 set line directions, 1 means output.
// - I/O control bits 9,8 set line output levels.
// - Auxiliary ADC result readable as 12-bit unsigned straight binary.
`timescale 1ns/10ps
`default_nettype none
module auxio_regs #(
  parameter int ST_HP_CYC = auxio_pkg::AUXIO_ST_HP_CYC,
  parameter int ST_LP_CYC = auxio_pkg::AUXIO_ST_LP_CYC,
  parameter int DR_OFF_CYC = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Byte write and read port from the serial interface
  input wire auxio_pkg::auxio_wr_s wr_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // Device status inputs
  input wire logic low_power_i,
  input wire logic sample_done_i,
  input wire logic [11:0] adc_result_i,
  input wire logic alm_own0_i,
  input wire logic alm_lvl0_i,
  input wire logic alm_own1_i,
  input wire logic alm_lvl1_i,
  // Analog and sensor controls
  output logic [11:0] dac_code_o,
  output logic reverse_rot_o,
  output logic self_check_o,
  // I/O lines, enable low while driving
  output logic io_line_zero_o,
  output logic io_line_zero_oe_n_o,
  output logic io_line_one_o,
  output logic io_line_one_oe_n_o
);
  // ==========================================================================
  // Registers and wires
  logic [15:0] dac_q;
  logic [15:0] gpio_q;
  logic [15:0] misc_vol_q;
  logic [2:0] misc_nv;
  logic [11:0] dac_out_q;
  logic rev_q;
  logic st_out_q;
  logic [7:0] rd_q;
  auxio_pkg::auxio_st_e st_q;
  auxio_pkg::auxio_st_e st_d;
  logic [31:0] st_cnt_q;
  logic [31:0] st_cnt_d;
  logic st_started_q;
  logic dr_act_q;
  logic [7:0] dr_cnt_q;
  logic [15:0] misc_full;
  logic [15:0] rd_word;
  logic wr_dac_lo;
  logic wr_dac_hi;
  logic wr_gpio_lo;
  logic wr_gpio_hi;
  logic wr_misc_lo;
  logic wr_misc_hi;
  logic latch_cmd;
  logic dr_en;
  logic dr_level;
  logic [31:0] st_len;

  // Byte address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input logic hi);
    hit = (a == (base | {7'h00, hi}));
  endfunction

  // ==========================================================================
  // Write decode
  assign wr_dac_lo = wr_i.valid & hit(wr_i.addr, auxio_pkg::AUXIO_ADDR_DAC, 1'b0);
  assign wr_dac_hi = wr_i.valid & hit(wr_i.addr, auxio_pkg::AUXIO_ADDR_DAC, 1'b1);
  assign wr_gpio_lo = wr_i.valid & hit(wr_i.addr, auxio_pkg::AUXIO_ADDR_GPIO, 1'b0);
  assign wr_gpio_hi = wr_i.valid & hit(wr_i.addr, auxio_pkg::AUXIO_ADDR_GPIO, 1'b1);
  assign wr_misc_lo = wr_i.valid & hit(wr_i.addr, auxio_pkg::AUXIO_ADDR_MISC, 1'b0);
  assign wr_misc_hi = wr_i.valid & hit(wr_i.addr, auxio_pkg::AUXIO_ADDR_MISC, 1'b1);
  assign latch_cmd = wr_i.valid & hit(wr_i.addr, auxio_pkg::AUXIO_ADDR_CMD, 1'b0)
    & wr_i.data[auxio_pkg::AUXIO_CMD_DAC_LATCH];

  // ==========================================================================
  // DAC data register, cleared on reset, unused bits held zero
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dac_q <= auxio_pkg::AUXIO_RST_DAC;
    end
    else
    begin
      if (wr_dac_lo)
      begin
        dac_q[7:0] <= wr_i.data & auxio_pkg::AUXIO_MASK_DAC[7:0];
      end
      if (wr_dac_hi)
      begin
        dac_q[15:8] <= wr_i.data & auxio_pkg::AUXIO_MASK_DAC[15:8];
      end
    end
  end

  // DAC output moves only on the latch command
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dac_out_q <= '0;
    end
    else if (latch_cmd)
    begin
      dac_out_q <= dac_q[auxio_pkg::AUXIO_DAC_W-1:0];
    end
  end

  // ==========================================================================
  // I/O control register, all inputs after reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gpio_q <= auxio_pkg::AUXIO_RST_GPIO;
    end
    else
    begin
      if (wr_gpio_lo)
      begin
        gpio_q[7:0] <= wr_i.data & auxio_pkg::AUXIO_MASK_GPIO[7:0];
      end
      if (wr_gpio_hi)
      begin
        gpio_q[15:8] <= wr_i.data & auxio_pkg::AUXIO_MASK_GPIO[15:8];
      end
    end
  end

  // ==========================================================================
  // Miscellaneous control: volatile upper byte, retained low bits
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      misc_vol_q <= auxio_pkg::AUXIO_RST_MISC;
    end
    else if (wr_misc_hi)
    begin
      misc_vol_q[15:8] <= wr_i.data & auxio_pkg::AUXIO_MASK_MISC[15:8];
    end
  end

  // Data-ready configuration survives reset
  auxio_nvstore #(
    .W(3)
  ) u_nv (
    .clk_i(clk_i),
    .we_i(wr_misc_lo),
    .wdata_i(wr_i.data[2:0]),
    .rdata_o(misc_nv)
  );

  assign misc_full = {misc_vol_q[15:8], 5'h00, misc_nv};

  // ==========================================================================
  // Read mux, unmapped bytes read zero
  always_comb
  begin
    rd_word = 16'h0000;
    case ({rd_addr_i[7:1], 1'b0})
      auxio_pkg::AUXIO_ADDR_DAC: rd_word = dac_q;
      auxio_pkg::AUXIO_ADDR_GPIO: rd_word = gpio_q;
      auxio_pkg::AUXIO_ADDR_MISC: rd_word = misc_full;
      auxio_pkg::AUXIO_ADDR_ADC: rd_word = {4'h0, adc_result_i};
      default: rd_word = 16'h0000;
    endcase
  end

  // Registered read byte
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_q <= '0;
    end
    else
    begin
      rd_q <= rd_addr_i[0] ? rd_word[15:8] : rd_word[7:0];
    end
  end

  // ==========================================================================
  // Self-check sequencer: power-up run, then continuous if enabled
  assign st_len = low_power_i ? 32'(ST_LP_CYC) : 32'(ST_HP_CYC);

  always_comb
  begin
    st_d = st_q;
    st_cnt_d = st_cnt_q;
    case (st_q)
      auxio_pkg::AUXIO_ST_IDLE:
      begin
        if (misc_vol_q[auxio_pkg::AUXIO_MISC_ST_EN])
        begin
          st_d = auxio_pkg::AUXIO_ST_CONT;
        end
        else if (!st_started_q && !misc_vol_q[auxio_pkg::AUXIO_MISC_NO_PWRUP_ST])
        begin
          st_d = auxio_pkg::AUXIO_ST_PWRUP;
          st_cnt_d = '0;
        end
      end
      auxio_pkg::AUXIO_ST_PWRUP:
      begin
        st_cnt_d = st_cnt_q + 32'd1;
        if (st_cnt_q >= st_len - 32'd1)
        begin
          st_d = auxio_pkg::AUXIO_ST_IDLE;
        end
      end
      auxio_pkg::AUXIO_ST_CONT:
      begin
        if (!misc_vol_q[auxio_pkg::AUXIO_MISC_ST_EN])
        begin
          st_d = auxio_pkg::AUXIO_ST_IDLE;
        end
      end
      default: st_d = auxio_pkg::AUXIO_ST_IDLE;
    endcase
  end

  // Sequencer state, power-up run happens once per reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= auxio_pkg::AUXIO_ST_IDLE;
      st_cnt_q <= '0;
      st_started_q <= 1'b0;
      st_out_q <= 1'b0;
      rev_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      st_cnt_q <= st_cnt_d;
      st_started_q <= 1'b1;
      st_out_q <= (st_d != auxio_pkg::AUXIO_ST_IDLE);
      rev_q <= misc_vol_q[auxio_pkg::AUXIO_MISC_REVERSE];
    end
  end

  // ==========================================================================
  // Data-ready pulse: active at sample done, off after a few cycles
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dr_act_q <= 1'b0;
      dr_cnt_q <= '0;
    end
    else if (sample_done_i)
    begin
      dr_act_q <= 1'b1;
      dr_cnt_q <= 8'(DR_OFF_CYC);
    end
    else if (dr_cnt_q != 8'h00)
    begin
      dr_cnt_q <= dr_cnt_q - 8'h01;
      dr_act_q <= (dr_cnt_q != 8'h01);
    end
  end

  assign dr_en = misc_nv[auxio_pkg::AUXIO_MISC_DR_EN];
  assign dr_level = misc_nv[auxio_pkg::AUXIO_MISC_DR_POL] ? dr_act_q : ~dr_act_q;

  // ==========================================================================
  // Pins with owner priority
  auxio_pin u_pin0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .dr_own_i(dr_en & ~misc_nv[auxio_pkg::AUXIO_MISC_DR_SEL]),
    .dr_lvl_i(dr_level),
    .alm_own_i(alm_own0_i),
    .alm_lvl_i(alm_lvl0_i),
    .dir_i(gpio_q[auxio_pkg::AUXIO_GPIO_DIR0]),
    .lvl_i(gpio_q[auxio_pkg::AUXIO_GPIO_LVL0]),
    .pin_o(io_line_zero_o),
    .pin_oe_n_o(io_line_zero_oe_n_o)
  );

  auxio_pin u_pin1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .dr_own_i(dr_en & misc_nv[auxio_pkg::AUXIO_MISC_DR_SEL]),
    .dr_lvl_i(dr_level),
    .alm_own_i(alm_own1_i),
    .alm_lvl_i(alm_lvl1_i),
    .dir_i(gpio_q[auxio_pkg::AUXIO_GPIO_DIR1]),
    .lvl_i(gpio_q[auxio_pkg::AUXIO_GPIO_LVL1]),
    .pin_o(io_line_one_o),
    .pin_oe_n_o(io_line_one_oe_n_o)
  );

  // Registered outputs
  assign dac_code_o = dac_out_q;
  assign reverse_rot_o = rev_q;
  assign self_check_o = st_out_q;
  assign rd_data_o = rd_q;
endmodule
`default_nettype wire

// ### auxio_pkg.sv
// Package for the auxiliary I/O control register block
package auxio_pkg;

  // ==========================================================================
  // Register byte addresses (each register is two bytes, low byte even)
  localparam logic [7:0] AUXIO_ADDR_DAC = 8'h30;
  localparam logic [7:0] AUXIO_ADDR_GPIO = 8'h32;
  localparam logic [7:0] AUXIO_ADDR_MISC = 8'h34;
  localparam logic [7:0] AUXIO_ADDR_CMD = 8'h3E;
  localparam logic [7:0] AUXIO_ADDR_ADC = 8'h0A;

  // ==========================================================================
  // Reset values and writable-bit masks
  localparam logic [15:0] AUXIO_RST_DAC = 16'h0000;
  localparam logic [15:0] AUXIO_RST_GPIO = 16'h0000;
  localparam logic [15:0] AUXIO_RST_MISC = 16'h0000;
  localparam logic [15:0] AUXIO_MASK_DAC = 16'h0FFF;
  localparam logic [15:0] AUXIO_MASK_GPIO = 16'h0303;
  localparam logic [15:0] AUXIO_MASK_MISC = 16'h0707;
  localparam logic [15:0] AUXIO_MASK_MISC_NV = 16'h0007;

  // ==========================================================================
  // Field positions
  localparam int AUXIO_MISC_NO_PWRUP_ST = 10;
  localparam int AUXIO_MISC_REVERSE = 9;
  localparam int AUXIO_MISC_ST_EN = 8;
  localparam int AUXIO_MISC_DR_EN = 2;
  localparam int AUXIO_MISC_DR_POL = 1;
  localparam int AUXIO_MISC_DR_SEL = 0;
  localparam int AUXIO_GPIO_LVL1 = 9;
  localparam int AUXIO_GPIO_LVL0 = 8;
  localparam int AUXIO_GPIO_DIR1 = 1;
  localparam int AUXIO_GPIO_DIR0 = 0;
  localparam int AUXIO_CMD_DAC_LATCH = 2;
  localparam int AUXIO_DAC_W = 12;
  localparam int AUXIO_ADC_W = 12;

  // ==========================================================================
  // Timing: power-up self-check length
  localparam int AUXIO_CLK_MHZ = 100;
  localparam int AUXIO_ST_HP_MS = 13;
  localparam int AUXIO_ST_LP_MS = 35;
  localparam int AUXIO_ST_HP_CYC = AUXIO_ST_HP_MS * 1000 * AUXIO_CLK_MHZ;
  localparam int AUXIO_ST_LP_CYC = AUXIO_ST_LP_MS * 1000 * AUXIO_CLK_MHZ;

  // ==========================================================================
  // Register write carrier
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } auxio_wr_s;

  // Self-check sequencer states
  typedef enum logic [1:0] {
    AUXIO_ST_IDLE,
    AUXIO_ST_PWRUP,
    AUXIO_ST_CONT
  } auxio_st_e;

endpackage

// ### auxio_nvstore.sv
// Nonvolatile holder for the data-ready configuration bits
`timescale 1ns/10ps
`default_nettype none
module auxio_nvstore #(
  parameter int W = 3
) (
  // Clock only: contents survive any reset
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [W-1:0] wdata_i,
  // Registered read data
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem_q = '0;

  // Storage with no reset, models retained nonvolatile bits
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_q <= wdata_i;
    end
  end

  assign rdata_o = mem_q;
endmodule
`default_nettype wire

// ### auxio_pin.sv
// One I/O line with owner priority between data-ready and plain control
`timescale 1ns/10ps
`default_nettype none
module auxio_pin (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data-ready claim
  input wire logic dr_own_i,
  input wire logic dr_lvl_i,
  // Alarm claim
  input wire logic alm_own_i,
  input wire logic alm_lvl_i,
  // Plain control claim
  input wire logic dir_i,
  input wire logic lvl_i,
  // Pin signals, enable low while driving
  output logic pin_o,
  output logic pin_oe_n_o
);
  logic drive_d;
  logic lvl_d;

  // Data-ready first, then alarm, then plain control
  assign drive_d = dr_own_i | alm_own_i | dir_i;
  assign lvl_d = dr_own_i ? dr_lvl_i : (alm_own_i ? alm_lvl_i : lvl_i);

  // Registered pin drive
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end
    else
    begin
      pin_o <= lvl_d;
      pin_oe_n_o <= ~drive_d;
    end
  end
endmodule
`default_nettype wire

// ### auxio_monitor.sv
// Port-level assertions for the auxiliary I/O register bank
`timescale 1ns/10ps
`default_nettype none
module auxio_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire auxio_pkg::auxio_wr_s wr_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic [7:0] rd_data_o,
  // Status inputs
  input wire logic sample_done_i,
  input wire logic alm_own0_i,
  input wire logic alm_lvl0_i,
  input wire logic alm_own1_i,
  // Outputs under watch
  input wire logic [11:0] dac_code_o,
  input wire logic reverse_rot_o,
  input wire logic self_check_o,
  input wire logic io_line_zero_o,
  input wire logic io_line_zero_oe_n_o,
  input wire logic io_line_one_o,
  input wire logic io_line_one_oe_n_o
);
  // ==========================================================================
  // Shadow copies of written control bits
  logic [2:0] dr_q = 3'h0;
  logic [1:0] st_q;
  logic [3:0] gio_q;

  // Bits that must read back as zero at the current read address
  wire logic [7:0] unused_mask = (rd_addr_i == 8'h31 || rd_addr_i == 8'h0B) ? 8'hF0 :
    (rd_addr_i[7:1] == 7'h19) ? 8'hFC : (rd_addr_i[7:1] == 7'h1A) ? 8'hF8 : 8'h00;

  // Latch command seen on the write port
  wire logic latch_seen = wr_i.valid && wr_i.addr == 8'h3E && wr_i.data[2];

  // Volatile shadows clear on reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= 2'h0;
      gio_q <= 4'h0;
    end
    else if (wr_i.valid)
    begin
      if (wr_i.addr == 8'h35)
        st_q <= wr_i.data[1:0];
      if (wr_i.addr == 8'h32)
        gio_q[1:0] <= wr_i.data[1:0];
      if (wr_i.addr == 8'h33)
        gio_q[3:2] <= wr_i.data[1:0];
    end
  end

  // Data-ready setup survives reset
  always @(posedge clk_i)
  begin
    if (wr_i.valid && wr_i.addr == 8'h34)
      dr_q <= wr_i.data[2:0];
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence dr0_on;
    io_line_zero_o == dr_q[1] && !io_line_zero_oe_n_o;
  endsequence

  dac_hold_a: assert property (
    $changed(dac_code_o) |-> $past(latch_seen))
    else $error("DAC output moved without a latch command");
  dr_pulse_a: assert property (
    sample_done_i && dr_q[2] && !dr_q[0] |-> ##2 dr0_on [*4] ##1 io_line_zero_o != dr_q[1])
    else $error("Data-ready pulse wrong on line zero");
  gpio_one_a: assert property (
    !(dr_q[2] && dr_q[0]) && !alm_own1_i |=> io_line_one_oe_n_o == !$past(gio_q[1])
    && (!$past(gio_q[1]) || io_line_one_o == $past(gio_q[3])))
    else $error("Line one does not follow I/O control");
  alarm_pri_a: assert property (
    alm_own0_i && !(dr_q[2] && !dr_q[0]) |=> !io_line_zero_oe_n_o && io_line_zero_o == $past(alm_lvl0_i))
    else $error("Alarm claim not honoured on line zero");
  unused_zero_a: assert property (
    ##1 (rd_data_o & $past(unused_mask)) == 8'h00)
    else $error("Unused bits read nonzero");
  st_cont_a: assert property (
    st_q[0] |-> ##[1:2] self_check_o)
    else $error("Continuous self-check not running");
  reverse_a: assert property (
    reverse_rot_o == $past(st_q[1]))
    else $error("Rotation reverse does not follow its bit");
  self_end_a: assert property (
    self_check_o && !st_q[0] |-> ##[1:45] !self_check_o)
    else $error("Power-up self-check overran");
endmodule

bind auxio_regs auxio_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_addr_i(rd_addr_i),
  .rd_data_o(rd_data_o), .sample_done_i(sample_done_i), .alm_own0_i(alm_own0_i), .alm_lvl0_i(alm_lvl0_i),
  .alm_own1_i(alm_own1_i), .dac_code_o(dac_code_o), .reverse_rot_o(reverse_rot_o),
  .self_check_o(self_check_o), .io_line_zero_o(io_line_zero_o), .io_line_zero_oe_n_o(io_line_zero_oe_n_o),
  .io_line_one_o(io_line_one_o), .io_line_one_oe_n_o(io_line_one_oe_n_o));
`default_nettype wire

// ### auxio_host.sv
// Host model issuing byte writes and reads on the register port
`timescale 1ns/10ps
`default_nettype none
module auxio_host (
  // Clock
  input wire logic clk_i,
  // Register port
  output var auxio_pkg::auxio_wr_s wr_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);
  // Idle port at time zero
  initial
  begin
    wr_o = '0;
    rd_addr_o = 8'h00;
  end

  // Byte write: strobe over one edge, then stale fields inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = '{valid: 1'b1, addr: a, data: d};
    @(negedge clk_i);
    wr_o = '{valid: 1'b0, addr: ~a, data: ~d};
  endtask

  // Byte read: data taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd_addr_o = a;
    @(negedge clk_i);
    d = rd_data_i;
  endtask
endmodule
`default_nettype wire

// ### auxio_regs_tb.sv
// Self-checking bench for the auxiliary I/O register bank
`timescale 1ns/10ps
`default_nettype none
module auxio_regs_tb;
  // ==========================================================================
  // Bench signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  auxio_pkg::auxio_wr_s wr_i;
  logic [7:0] rd_addr_i;
  logic [7:0] rd_data_o;
  logic sample_done_i = 1'b0;
  logic [11:0] adc_result_i = 12'hABC;
  logic low_power_i = 1'b0;
  logic alm_own0_i = 1'b0;
  logic alm_lvl0_i = 1'b0;
  logic alm_own1_i = 1'b0;
  logic alm_lvl1_i = 1'b0;
  // Short self-check lengths for simulation
  localparam int ST_HP = 20;
  localparam int ST_LP = 40;
  logic [11:0] dac_code_o;
  logic reverse_rot_o, self_check_o, z_o, z_oe_n, o_o, o_oe_n;
  int miscompares = 0;
  int total_checks = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // ==========================================================================
  // Design and host model
  auxio_regs #(.ST_HP_CYC(ST_HP), .ST_LP_CYC(ST_LP), .DR_OFF_CYC(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .low_power_i(low_power_i),
    .sample_done_i(sample_done_i), .adc_result_i(adc_result_i), .alm_own0_i(alm_own0_i),
    .alm_lvl0_i(alm_lvl0_i), .alm_own1_i(alm_own1_i), .alm_lvl1_i(alm_lvl1_i), .dac_code_o(dac_code_o),
    .reverse_rot_o(reverse_rot_o), .self_check_o(self_check_o), .io_line_zero_o(z_o),
    .io_line_zero_oe_n_o(z_oe_n), .io_line_one_o(o_o), .io_line_one_oe_n_o(o_oe_n));
  auxio_host host (.clk_i(clk_i), .wr_o(wr_i), .rd_addr_o(rd_addr_i), .rd_data_i(rd_data_o));

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  task automatic pulse_done;
    sample_done_i = 1'b1;
    cyc(1);
    sample_done_i = 1'b0;
    cyc(2);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Reset release, then bounded count of the power-up self-check length
  task automatic reset_and_settle(input int len);
    int n;
    rst_i = 1'b0;
    cyc(4);
    chk({15'h0, self_check_o}, 16'h0001);
    n = 0;
    while (self_check_o !== 1'b0 && n < 200)
    begin
      cyc(1);
      n++;
    end
    if (n == 200)
    begin
      miscompares++;
      $display("MISMATCH t=%0t self-check never ended", $time);
      tally_and_finish();
    end
    // High from the first edge after release, low once it has run len cycles
    chk(16'(n + 3), 16'(len));
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    cyc(8);
    reset_and_settle(ST_HP);
    for (int a = 8'h30; a < 8'h36; a++)
      rchk(a[7:0], 8'h00);
    host.wr(8'h30, 8'hAB);
    host.wr(8'h31, 8'hFF);
    rchk(8'h31, 8'h0F);
    chk({4'h0, dac_code_o}, 16'h0000);
    host.wr(8'h3E, 8'h04);
    cyc(1);
    chk({4'h0, dac_code_o}, 16'h0FAB);
    rchk(8'h0A, 8'hBC);
    rchk(8'h0B, 8'h0A);
    adc_result_i = 12'h5F3;
    rchk(8'h0B, 8'h05);
    rchk(8'h40, 8'h00);
    host.wr(8'h32, 8'h03);
    host.wr(8'h33, 8'hFE);
    rchk(8'h33, 8'h02);
    chk({12'h0, z_oe_n, o_oe_n, z_o, o_o}, 16'h0001);
    alm_own0_i = 1'b1;
    alm_lvl0_i = 1'b1;
    cyc(2);
    chk({15'h0, z_o}, 16'h0001);
    alm_own1_i = 1'b1;
    host.wr(8'h34, 8'h06);
    cyc(2);
    chk({14'h0, z_o, o_o}, 16'h0000);
    pulse_done();
    chk({15'h0, z_o}, 16'h0001);
    cyc(3);
    chk({15'h0, z_o}, 16'h0000);
    host.wr(8'h34, 8'h05);
    cyc(2);
    chk({13'h0, z_o, o_o, o_oe_n}, 16'h0006);
    pulse_done();
    chk({15'h0, o_o}, 16'h0000);
    host.wr(8'h35, 8'hFF);
    rchk(8'h35, 8'h07);
    chk({14'h0, reverse_rot_o, self_check_o}, 16'h0003);
    host.wr(8'h35, 8'h04);
    cyc(2);
    chk({14'h0, reverse_rot_o, self_check_o}, 16'h0000);
    low_power_i = 1'b1;
    rst_i = 1'b1;
    cyc(2);
    reset_and_settle(ST_LP);
    rchk(8'h34, 8'h05);
    rchk(8'h35, 8'h00);
    rchk(8'h32, 8'h00);
    rchk(8'h30, 8'h00);
    chk({4'h0, dac_code_o}, 16'h0000);
    alm_lvl1_i = 1'b1;
    host.wr(8'h34, 8'h00);
    cyc(2);
    chk({14'h0, o_o, o_oe_n}, 16'h0002);
    tally_and_finish();
  end
endmodule
`default_nettype wire
